// ==== bench/mtcf_cpu_model.sv ====
// CPU side model: APB master and channel pin driver.
// Assumes pclk from the bench; signals change only after rising edges.
`timescale 1ns/10ps
module mtcf_cpu_model (
	input wire logic pclk,
	input wire mtcf_pkg::mtcf_apb_rsp_t apb_rsp,
	output mtcf_pkg::mtcf_apb_req_t apb_req,
	output logic [mtcf_pkg::CH_N-1:0] channel_pin
);
	import mtcf_pkg::*;
	logic hung;
	initial begin
		apb_req = '0;
		channel_pin = '0;
		hung = 1'b0;
	end
	// Setup, then access held until pready
	task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int n;
		n = 0;
		@(posedge pclk);
		apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
		@(posedge pclk);
		apb_req.penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (apb_rsp.pready !== 1'b1 && n < 64);
		hung = (n >= 64);
		r = apb_rsp.prdata;
		e = apb_rsp.pslverr;
		apb_req <= '0;
	endtask
	task automatic pin(input int i, input logic v);
		@(posedge pclk);
		channel_pin[i] <= v;
		repeat (2) @(posedge pclk);
	endtask
endmodule

// ==== bench/tb.sv ====
// Testbench of the modulo timer core: registers, counting, flags, modes.
// Assumes the CPU model drives the bus and the channel pins.
`timescale 1ns/10ps
module tb;
	import mtcf_pkg::*;
	typedef struct packed {
		logic [7:0] a;
		logic [7:0] d;
		logic e;
	} mtcf_row_t;
	logic pclk;
	logic presetn;
	mtcf_apb_req_t apb_req;
	mtcf_apb_rsp_t apb_rsp;
	mtcf_sys_t sys_mode;
	logic [CH_N-1:0] channel_pin;
	logic overflow_irq;
	logic [CH_N-1:0] channel_irq;
	int num_errors;
	int comparisons;
	logic [31:0] rdat;
	logic rerr;
	logic [15:0] cnt;
	logic [15:0] c0;
	logic [15:0] ex;
	logic [7:0] lat;
	mtcf_row_t rows [8] = '{'{OFF_SC, 8'h20, 1'b0}, '{OFF_CNTH, 8'h00, 1'b0},
		'{OFF_CNTL, 8'h00, 1'b0}, '{OFF_MODH, 8'hff, 1'b0}, '{OFF_MODL, 8'hff, 1'b0},
		'{OFF_CHSC[0], 8'h00, 1'b0}, '{OFF_CHSC[1], 8'h00, 1'b0}, '{8'h3c, 8'h00, 1'b1}};
	mtcf_timer uut (.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
		.sys_mode(sys_mode), .channel_pin(channel_pin), .overflow_irq(overflow_irq),
		.channel_irq(channel_irq));
	mtcf_cpu_model cpu (.pclk(pclk), .apb_rsp(apb_rsp), .apb_req(apb_req),
		.channel_pin(channel_pin));
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wrap_up();
		if (num_errors == 0 && comparisons > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		cpu.xfer(w, a, {24'h000000, d}, rdat, rerr);
		if (cpu.hung) begin
			num_errors++;
			wrap_up();
		end
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		bus(1'b0, a, 8'h00);
		check(rdat, {24'h000000, exp});
	endtask
	task automatic rd_cnt();
		bus(1'b0, OFF_CNTH, 8'h00);
		cnt[15:8] = rdat[7:0];
		bus(1'b0, OFF_CNTL, 8'h00);
		cnt[7:0] = rdat[7:0];
	endtask
	task automatic setm(input logic [3:0] m);
		@(posedge pclk);
		sys_mode <= mtcf_sys_t'(m);
	endtask
	initial begin
		num_errors = 0;
		comparisons = 0;
		presetn = 1'b0;
		sys_mode = '0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		foreach (rows[i]) begin
			bus(1'b0, rows[i].a, 8'h00);
			check({31'h0, rerr}, {31'h0, rows[i].e});
			if (!rows[i].e) check(rdat, {24'h0, rows[i].d});
		end
		bus(1'b1, OFF_MODH, 8'h00);
		bus(1'b1, OFF_SC, 8'h00);
		repeat (300) @(posedge pclk);
		bus(1'b1, OFF_SC, 8'h20);
		rd_chk(OFF_SC, 8'h20);
		bus(1'b1, OFF_SC, 8'h30);
		bus(1'b1, OFF_MODL, 8'h03);
		bus(1'b1, OFF_SC, 8'h00);
		repeat (10) @(posedge pclk);
		bus(1'b1, OFF_SC, 8'h60);
		rd_cnt();
		check({31'h0, cnt <= 16'h0003}, 32'h1);
		rd_chk(OFF_SC, 8'he0);
		check({31'h0, overflow_irq}, 32'h1);
		bus(1'b1, OFF_SC, 8'h60);
		rd_chk(OFF_SC, 8'h60);
		check({31'h0, overflow_irq}, 32'h0);
		bus(1'b1, OFF_SC, 8'h70);
		rd_chk(OFF_SC, 8'h60);
		rd_cnt();
		check({16'h0, cnt}, 32'h0);
		bus(1'b1, OFF_MODH, 8'hff);
		bus(1'b1, OFF_MODL, 8'hff);
		for (int k = 0; k < 8; k++) begin
			bus(1'b1, OFF_SC, 8'h10 | 8'(k));
			repeat (253) @(posedge pclk);
			bus(1'b1, OFF_SC, 8'h20 | 8'(k));
			rd_chk(OFF_SC, 8'h20 | 8'(k));
			rd_cnt();
			ex = (k < 7) ? (16'h0100 >> k) : 16'h0000;
			check({31'h0, cnt + 16'h1 >= ex && cnt <= ex + 16'h1}, 32'h1);
		end
		bus(1'b1, OFF_SC, 8'h16);
		repeat (640) @(posedge pclk);
		bus(1'b0, OFF_CNTH, 8'h00);
		repeat (1280) @(posedge pclk);
		bus(1'b0, OFF_CNTH, 8'h00);
		bus(1'b0, OFF_CNTL, 8'h00);
		lat = rdat[7:0];
		bus(1'b1, OFF_SC, 8'h26);
		rd_cnt();
		check({31'h0, lat >= 8'h09 && lat + 8'h08 < cnt[7:0]}, 32'h1);
		bus(1'b1, OFF_SC, 8'h00);
		setm(4'b1000);
		bus(1'b0, OFF_SC, 8'h00);
		check({31'h0, rerr}, 32'h1);
		setm(4'b0100);
		rd_cnt();
		c0 = cnt;
		repeat (20) @(posedge pclk);
		rd_cnt();
		check({16'h0, cnt}, {16'h0, c0});
		setm(4'b0000);
		bus(1'b1, OFF_SC, 8'h30);
		bus(1'b1, OFF_MODH, 8'h00);
		bus(1'b1, OFF_MODL, 8'h07);
		bus(1'b1, OFF_CHSC[0], 8'h41);
		cpu.pin(0, 1'b1);
		rd_chk(OFF_CHSC[0], 8'h41);
		bus(1'b1, OFF_SC, 8'h00);
		setm(4'b0010);
		cpu.pin(0, 1'b0);
		cpu.pin(0, 1'b1);
		rd_chk(OFF_CHSC[0], 8'h41);
		setm(4'b0000);
		cpu.pin(0, 1'b0);
		cpu.pin(0, 1'b1);
		rd_chk(OFF_CHSC[0], 8'hc1);
		check({30'h0, channel_irq}, 32'h1);
		bus(1'b1, OFF_CHSC[0], 8'h41);
		rd_chk(OFF_CHSC[0], 8'h41);
		bus(1'b1, OFF_CHVAL[1], 8'h02);
		bus(1'b1, OFF_CHSC[1], 8'h04);
		repeat (20) @(posedge pclk);
		bus(1'b1, OFF_SC, 8'h20);
		rd_chk(OFF_CHSC[1], 8'h84);
		check({30'h0, channel_irq}, 32'h0);
		setm(4'b0010);
		bus(1'b1, OFF_CHSC[1], 8'h04);
		rd_chk(OFF_CHSC[1], 8'h84);
		setm(4'b0000);
		bus(1'b1, OFF_CHSC[1], 8'h04);
		rd_chk(OFF_CHSC[1], 8'h04);
		bus(1'b1, OFF_SC, 8'h00);
		repeat (20) @(posedge pclk);
		bus(1'b1, OFF_SC, 8'h20);
		setm(4'b0011);
		rd_chk(OFF_CHSC[1], 8'h84);
		bus(1'b1, OFF_CHSC[1], 8'h04);
		setm(4'b0000);
		rd_chk(OFF_CHSC[1], 8'h04);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rd_chk(OFF_SC, 8'h20);
		rd_chk(OFF_MODL, 8'hff);
		rd_chk(OFF_CHSC[1], 8'h00);
		check({31'h0, overflow_irq}, 32'h0);
		wrap_up();
	end
endmodule

// ==== logic/mtcf_pkg.sv ====
// Constants, register map and carrier types of the modulo timer core.
// Assumes an APB slave with byte addresses and 8-bit registers in the low bits.
package mtcf_pkg;
	localparam int CH_N = 2;
	localparam int CNT_W = 16;
	localparam int PRESC_W = 6;
	localparam int ADDR_W = 8;
	localparam int BYTE_W = 8;

	localparam logic [ADDR_W-1:0] OFF_SC = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_CNTH = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_CNTL = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_MODH = 8'h0c;
	localparam logic [ADDR_W-1:0] OFF_MODL = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_CHSC [CH_N] = '{8'h14, 8'h18};
	localparam logic [ADDR_W-1:0] OFF_CHVAL [CH_N] = '{8'h1c, 8'h20};

	localparam int SC_OVF = 7;
	localparam int SC_OIE = 6;
	localparam int SC_HALT = 5;
	localparam int SC_CLR = 4;
	localparam int SC_PS_HI = 2;
	localparam int SC_PS_LO = 0;
	localparam int CH_FLAG = 7;
	localparam int CH_IE = 6;
	localparam int CH_CMP = 2;
	localparam int CH_FALL = 1;
	localparam int CH_RISE = 0;

	localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
	localparam logic [CNT_W-1:0] MOD_RST = 16'hffff;
	localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
	localparam logic [PRESC_W-1:0] PRESC_RST = 6'h00;
	localparam logic [PRESC_W-1:0] PRESC_ONE = 6'h01;
	localparam logic [2:0] PS_RST = 3'h0;
	localparam logic [2:0] PS_UNUSED = 3'h7;
	localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;
	localparam logic [23:0] RD_PAD = 24'h000000;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [31:0] pwdata;
	} mtcf_apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} mtcf_apb_rsp_t;

	typedef struct packed {
		logic wait_mode;
		logic stop_mode;
		logic debug_break;
		logic break_clear_enable;
	} mtcf_sys_t;
endpackage

// ==== logic/mtcf_timer.sv ====
// Modulo timer core with prescaler, overflow flag and two capture/compare channels.
// Assumes an APB master on pclk and channel pins synchronous to pclk.
//
// Implementation choices: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps

// Summary of operation
// - Counter equal modulo sets flag, restarts zero
// - Overflow flag clears by read-set then write-0
// - Overflow irq when flag and enable set
// - Halt bit freezes counter; reset sets it
// - Halt suppresses input captures
// - Clear bit zeroes counter and prescaler, self-clears
// - Halt with clear leaves counter stopped at zero
// - Prescale select divides by 1 to 64
// - Prescaler fed only by bus clock
// - High byte read latches low byte
// - Counter bytes read zero after reset, clear
// - Modulo high write blocks overflow until low
// - Modulo resets to all ones
// - Capture edge sets channel event flag
// - Compare match sets channel event flag
// - Channel flag clears by read-set then write-0
// - Channel irq when flag and enable set
// - Wait mode keeps counting, blocks register access
// - Stop mode freezes counter and prescaler, state preserved
// - Debug break freezes counter, blocks captures
// - Break without clear enable protects flags
module mtcf_timer (
	input wire logic pclk,
	input wire logic presetn,
	input wire mtcf_pkg::mtcf_apb_req_t apb_req,
	output mtcf_pkg::mtcf_apb_rsp_t apb_rsp,
	input wire mtcf_pkg::mtcf_sys_t sys_mode,
	input wire logic [mtcf_pkg::CH_N-1:0] channel_pin,
	output logic overflow_irq,
	output logic [mtcf_pkg::CH_N-1:0] channel_irq
);
	import mtcf_pkg::*;

	function automatic logic presc_tick(logic [2:0] ps, logic [PRESC_W-1:0] p);
		logic [PRESC_W-1:0] m;
		m = PRESC_W'((7'h01 << ps) - 7'h01);
		return (ps != PS_UNUSED) && ((p & m) == m);
	endfunction

	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] mod_q;
	logic [CNT_W-1:0] cnt_nx;
	logic [PRESC_W-1:0] presc_q;
	logic [2:0] ps_q;
	logic halt_q;
	logic oie_q;
	logic ovf_q;
	logic ovf_arm_q;
	logic mod_inh_q;
	logic latch_q;
	logic [BYTE_W-1:0] buf_q;
	logic [BYTE_W-1:0] snap_q;
	logic [BYTE_W-1:0] rdata;
	logic hit;
	logic chf_q [CH_N];
	logic chie_q [CH_N];
	logic chcmp_q [CH_N];
	logic chrise_q [CH_N];
	logic chfall_q [CH_N];
	logic charm_q [CH_N];
	logic pin_q [CH_N];
	logic [CNT_W-1:0] chval_q [CH_N];

	logic setup;
	logic done;
	logic wr;
	logic rd;
	logic frz;
	logic run;
	logic lock;
	logic sc_w;
	logic sc_r;
	logic clr_p;
	logic tick;
	logic wrap;
	logic ovf_set;
	logic ovf_clr;

	assign setup = apb_req.psel && !apb_req.penable;
	assign done = apb_req.psel && apb_req.penable && apb_rsp.pready;
	assign wr = done && !apb_rsp.pslverr && apb_req.pwrite;
	assign rd = done && !apb_rsp.pslverr && !apb_req.pwrite;
	assign frz = sys_mode.stop_mode || sys_mode.debug_break;
	assign run = !halt_q && !frz;
	assign lock = sys_mode.debug_break && !sys_mode.break_clear_enable;
	assign sc_w = wr && (apb_req.paddr == OFF_SC);
	assign sc_r = rd && (apb_req.paddr == OFF_SC);
	assign clr_p = sc_w && apb_req.pwdata[SC_CLR];
	assign tick = run && presc_tick(ps_q, presc_q);
	assign wrap = tick && (cnt_q == mod_q);
	assign ovf_set = wrap && !mod_inh_q;
	assign ovf_clr = sc_w && !apb_req.pwdata[SC_OVF] && ovf_arm_q && !lock;
	assign cnt_nx = wrap ? CNT_RST : cnt_q + CNT_ONE;

	// Read data mux, sampled at the setup edge
	always_comb begin
		rdata = BYTE_ZERO;
		hit = 1'b1;
		unique case (apb_req.paddr)
			OFF_SC: begin
				rdata[SC_OVF] = ovf_q;
				rdata[SC_OIE] = oie_q;
				rdata[SC_HALT] = halt_q;
				rdata[SC_PS_HI:SC_PS_LO] = ps_q;
			end
			OFF_CNTH: begin
				rdata = cnt_q[CNT_W-1:BYTE_W];
			end
			OFF_CNTL: begin
				rdata = latch_q ? buf_q : cnt_q[BYTE_W-1:0];
			end
			OFF_MODH: begin
				rdata = mod_q[CNT_W-1:BYTE_W];
			end
			OFF_MODL: begin
				rdata = mod_q[BYTE_W-1:0];
			end
			default: begin
				hit = 1'b0;
			end
		endcase
		for (int i = 0; i < CH_N; i++) begin
			if (apb_req.paddr == OFF_CHSC[i]) begin
				hit = 1'b1;
				rdata[CH_FLAG] = chf_q[i];
				rdata[CH_IE] = chie_q[i];
				rdata[CH_CMP] = chcmp_q[i];
				rdata[CH_FALL] = chfall_q[i];
				rdata[CH_RISE] = chrise_q[i];
			end
			if (apb_req.paddr == OFF_CHVAL[i]) begin
				hit = 1'b1;
				rdata = chval_q[i][BYTE_W-1:0];
			end
		end
	end

	// Bus answer: ready in the first access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			apb_rsp <= '0;
			snap_q <= BYTE_ZERO;
		end else begin
			apb_rsp.pready <= setup;
			if (setup) begin
				apb_rsp.prdata <= {RD_PAD, rdata};
				apb_rsp.pslverr <= !hit || sys_mode.wait_mode;
				snap_q <= cnt_q[BYTE_W-1:0];
			end else begin
				apb_rsp.pslverr <= 1'b0;
			end
		end
	end

	// Control bits of the status register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ps_q <= PS_RST;
			halt_q <= 1'b1;
			oie_q <= 1'b0;
		end else if (sc_w) begin
			ps_q <= apb_req.pwdata[SC_PS_HI:SC_PS_LO];
			halt_q <= apb_req.pwdata[SC_HALT];
			oie_q <= apb_req.pwdata[SC_OIE];
		end
	end

	// Overflow flag and its clear sequence; a set wins over a clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ovf_q <= 1'b0;
			ovf_arm_q <= 1'b0;
		end else begin
			if (ovf_set) begin
				ovf_q <= 1'b1;
			end else if (ovf_clr) begin
				ovf_q <= 1'b0;
			end
			if (ovf_set) begin
				ovf_arm_q <= 1'b0;
			end else if (sc_r && apb_rsp.prdata[SC_OVF] && !lock) begin
				ovf_arm_q <= 1'b1;
			end else if (sc_w && !lock) begin
				ovf_arm_q <= 1'b0;
			end
		end
	end

	// Prescaler and counter
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			presc_q <= PRESC_RST;
			cnt_q <= CNT_RST;
		end else if (clr_p) begin
			presc_q <= PRESC_RST;
			cnt_q <= CNT_RST;
		end else if (run) begin
			presc_q <= presc_q + PRESC_ONE;
			if (tick) begin
				cnt_q <= cnt_nx;
			end
		end
	end

	// Low byte latch for coherent counter reads
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			latch_q <= 1'b0;
			buf_q <= BYTE_ZERO;
		end else if (clr_p) begin
			latch_q <= 1'b0;
			buf_q <= BYTE_ZERO;
		end else if (rd && (apb_req.paddr == OFF_CNTH) && !latch_q) begin
			latch_q <= 1'b1;
			buf_q <= snap_q;
		end else if (rd && (apb_req.paddr == OFF_CNTL)) begin
			latch_q <= 1'b0;
		end
	end

	// Modulo bytes and overflow inhibit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mod_q <= MOD_RST;
			mod_inh_q <= 1'b0;
		end else if (wr && (apb_req.paddr == OFF_MODH)) begin
			mod_q[CNT_W-1:BYTE_W] <= apb_req.pwdata[BYTE_W-1:0];
			mod_inh_q <= 1'b1;
		end else if (wr && (apb_req.paddr == OFF_MODL)) begin
			mod_q[BYTE_W-1:0] <= apb_req.pwdata[BYTE_W-1:0];
			mod_inh_q <= 1'b0;
		end
	end

	// Interrupt requests, also the wake source in wait mode
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			overflow_irq <= 1'b0;
			channel_irq <= '0;
		end else begin
			overflow_irq <= ovf_q && oie_q;
			for (int i = 0; i < CH_N; i++) begin
				channel_irq[i] <= chf_q[i] && chie_q[i];
			end
		end
	end

	// Capture/compare channels
	for (genvar i = 0; i < CH_N; i++) begin : g_ch
		logic csc_w;
		logic csc_r;
		logic cval_w;
		logic rise;
		logic fall;
		logic cap_evt;
		logic cmp_evt;
		logic evt;
		logic ch_clr;

		assign csc_w = wr && (apb_req.paddr == OFF_CHSC[i]);
		assign csc_r = rd && (apb_req.paddr == OFF_CHSC[i]);
		assign cval_w = wr && (apb_req.paddr == OFF_CHVAL[i]);
		assign rise = channel_pin[i] && !pin_q[i];
		assign fall = !channel_pin[i] && pin_q[i];
		// Captures need a running counter
		assign cap_evt = !chcmp_q[i] && run && ((rise && chrise_q[i]) || (fall && chfall_q[i]));
		assign cmp_evt = chcmp_q[i] && tick && (cnt_nx == chval_q[i]);
		assign evt = cap_evt || cmp_evt;
		assign ch_clr = csc_w && !apb_req.pwdata[CH_FLAG] && charm_q[i] && !lock;

		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				chie_q[i] <= 1'b0;
				chcmp_q[i] <= 1'b0;
				chrise_q[i] <= 1'b0;
				chfall_q[i] <= 1'b0;
			end else if (csc_w) begin
				chie_q[i] <= apb_req.pwdata[CH_IE];
				chcmp_q[i] <= apb_req.pwdata[CH_CMP];
				chrise_q[i] <= apb_req.pwdata[CH_RISE];
				chfall_q[i] <= apb_req.pwdata[CH_FALL];
			end
		end

		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				pin_q[i] <= 1'b0;
				chval_q[i] <= CNT_RST;
			end else begin
				pin_q[i] <= channel_pin[i];
				if (cap_evt) begin
					chval_q[i] <= cnt_q;
				end else if (cval_w) begin
					chval_q[i] <= apb_req.pwdata[CNT_W-1:0];
				end
			end
		end

		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				chf_q[i] <= 1'b0;
				charm_q[i] <= 1'b0;
			end else begin
				if (evt) begin
					chf_q[i] <= 1'b1;
				end else if (ch_clr) begin
					chf_q[i] <= 1'b0;
				end
				if (evt) begin
					charm_q[i] <= 1'b0;
				end else if (csc_r && apb_rsp.prdata[CH_FLAG] && !lock) begin
					charm_q[i] <= 1'b1;
				end else if (csc_w && !lock) begin
					charm_q[i] <= 1'b0;
				end
			end
		end
	end

	// Checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_ovf_wrap: assert property (ovf_set && !clr_p |=> ovf_q && cnt_q == CNT_RST)
		else $error("overflow did not set flag and restart");
	a_ovf_noarm: assert property (ovf_q && !ovf_arm_q |=> ovf_q)
		else $error("overflow flag cleared without read step");
	a_ovf_irq: assert property (ovf_q && oie_q |=> overflow_irq)
		else $error("overflow irq missing");
	a_halt_hold: assert property (halt_q && !clr_p |=> cnt_q == $past(cnt_q))
		else $error("counter moved while halted");
	a_halt_nocap: assert property (halt_q |-> !g_ch[0].cap_evt && !g_ch[1].cap_evt)
		else $error("capture while halted");
	a_clear_zero: assert property (clr_p |=> cnt_q == CNT_RST && presc_q == PRESC_RST)
		else $error("clear did not zero counter");
	a_halt_clear: assert property (clr_p && apb_req.pwdata[SC_HALT]
		|=> (cnt_q == CNT_RST)[*2])
		else $error("halted clear did not hold zero");
	a_mod_inh: assert property (mod_inh_q |=> !$rose(ovf_q))
		else $error("overflow set while modulo write pending");
	a_brk_freeze: assert property (sys_mode.debug_break && !clr_p |=> $stable(cnt_q))
		else $error("counter moved in break");
	a_stop_freeze: assert property (sys_mode.stop_mode && !clr_p
		|=> $stable(cnt_q) && $stable(presc_q))
		else $error("timer moved in stop");
	a_ch_irq: assert property (chf_q[0] && chie_q[0] |=> channel_irq[0])
		else $error("channel irq missing");
	a_brk_lock: assert property (lock && ovf_q |=> ovf_q)
		else $error("flag cleared in protected break");
	a_brk_chlock: assert property (lock && chf_q[1] |=> chf_q[1])
		else $error("channel flag cleared in protected break");
	a_irq_drop: assert property (!ovf_q |=> !overflow_irq)
		else $error("overflow irq without flag");
	a_ps_unused: assert property (ps_q == PS_UNUSED |-> !tick)
		else $error("counter ticked on unused prescale code");
	a_latch_hold: assert property (latch_q && !clr_p
		&& !(rd && apb_req.paddr == OFF_CNTL) |=> $stable(buf_q))
		else $error("latched low byte changed");
	a_clear_latch: assert property (clr_p |=> !latch_q && buf_q == BYTE_ZERO)
		else $error("clear left low byte latched");
	a_cap_flag: assert property (g_ch[0].cap_evt |=> chf_q[0])
		else $error("capture did not set channel flag");
	a_cmp_flag: assert property (g_ch[1].cmp_evt |=> chf_q[1])
		else $error("compare did not set channel flag");
	a_ch_noarm: assert property (chf_q[0] && !charm_q[0] |=> chf_q[0])
		else $error("channel flag cleared without read step");

	c_overflow: cover property (ovf_set);
	c_capture: cover property (g_ch[0].cap_evt);
	c_compare: cover property (g_ch[1].cmp_evt);
	c_latched: cover property (latch_q ##1 !latch_q);
	c_brk_clear: cover property (sys_mode.debug_break && !lock && g_ch[1].ch_clr);
endmodule
